// >>> rtl/timer_b_pkg.sv
package timer_b_pkg;

    // register byte addresses on the wishbone port
    localparam logic [3:0] CONTROL_ADDR    = 4'h0;
    localparam logic [3:0] MODE_ADDR       = 4'h4;
    localparam logic [3:0] IRQ_STATUS_ADDR = 4'h8;
    localparam logic [3:0] IRQ_MASK_ADDR   = 4'hC;

    // timer_b_control field positions
    localparam int CTL_OVERFLOW_BIT  = 7;
    localparam int CTL_EXT_FLAG_BIT  = 6;
    localparam int CTL_RX_SEL_BIT    = 5;
    localparam int CTL_TX_SEL_BIT    = 4;
    localparam int CTL_EXT_EN_BIT    = 3;
    localparam int CTL_RUN_BIT       = 2;
    localparam int CTL_CNT_SEL_BIT   = 1;
    localparam int CTL_CAP_SEL_BIT   = 0;

    // mode register field positions
    localparam int MODE_UP_DOWN_BIT  = 0;
    localparam int MODE_CLK_OUT_BIT  = 1;

    // interrupt status and mask field positions
    localparam int IRQ_OVERFLOW_BIT  = 0;
    localparam int IRQ_EXT_EVENT_BIT = 1;

    // reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [1:0] MODE_RESET    = 2'h0;
    localparam logic [1:0] IRQ_RESET     = 2'h0;

    // trigger pin synchroniser depth
    localparam int SYNC_STAGES = 3;

endpackage : timer_b_pkg

// >>> rtl/trigger_edge_sync.sv
`timescale 1ns/1ns

module trigger_edge_sync
    import timer_b_pkg::*;
#(
    parameter int STAGES = SYNC_STAGES
)
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // asynchronous pin and detected edge
    input  wire logic pin_i,
    output logic      fall_o
);

    logic [STAGES-1:0] sync_reg;
    logic [STAGES-1:0] sync_next;
    logic              level_reg;
    logic              level_next;

    // the logic compares the last two stages only
    initial
    begin
        if (STAGES != 3)
            $error("trigger_edge_sync supports exactly three stages");
    end

    // shift the pin in; reset parks the line high so no false edge appears
    // the level only moves once the last two stages agree: a cycle later, but a lone glitch is dropped
    always_comb
    begin
        sync_next  = {sync_reg[STAGES-2:0], pin_i};
        level_next = (sync_reg[STAGES-1] == sync_reg[STAGES-2]) ? sync_reg[STAGES-1] : level_reg;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync_reg  <= '1;
            level_reg <= 1'b1;
        end
        else
        begin
            sync_reg  <= sync_next;
            level_reg <= level_next;
        end
    end

    // falling edge: settled level was high and is about to go low; stage 0 is never looked at
    assign fall_o = level_reg & ~level_next;

endmodule : trigger_edge_sync

// >>> rtl/timer_b_ctrl.sv
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/1ns

module timer_b_ctrl
    import timer_b_pkg::*;
#(
    parameter int DATA_W = 32
)
(
    // system clock and synchronous reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // classic wishbone slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [3:0]        adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [DATA_W-1:0] dat_i,
    output logic      [DATA_W-1:0] dat_o,
    output logic                   ack_o,
    // counter datapath
    input  wire logic              timer_b_overflow_i,
    input  wire logic              timer_a_overflow_i,
    output logic                   timer_b_run_o,
    output logic                   count_events_o,
    output logic                   up_down_count_enable_o,
    output logic                   capture_o,
    output logic                   reload_o,
    // external trigger pin
    input  wire logic              external_trigger_pin_i,
    // uart baud pulses
    output logic                   uart_rx_baud_o,
    output logic                   uart_tx_baud_o,
    // interrupts
    output logic                   timer_irq_o,
    output logic                   irq_o
);

    initial
    begin
        if (DATA_W != 32)
            $error("timer_b_ctrl needs a 32-bit wishbone data path");
    end

    // state
    logic [7:0]        control_reg, control_next;
    logic [1:0]        mode_reg, mode_next;
    logic [1:0]        status_reg, status_next;
    logic [1:0]        mask_reg, mask_next;
    logic              ack_reg, ack_next;
    logic [DATA_W-1:0] dat_reg, dat_next;
    logic              capture_reg, capture_next;
    logic              reload_reg, reload_next;
    logic              rx_baud_reg, rx_baud_next;
    logic              tx_baud_reg, tx_baud_next;
    logic              timer_irq_reg, timer_irq_next;
    logic              irq_reg, irq_next;

    // decoded conditions
    logic trig_fall;
    logic bus_req;
    logic wr_en;
    logic baud_mode;
    logic special_mode;
    logic capture_mode;
    logic reload_mode;
    logic up_down;
    logic ext_en;
    logic edge_act;
    logic flag_set_ovf;
    logic flag_set_ext;
    logic flag_toggle;

    // synchroniser and falling edge detector for the trigger pin
    trigger_edge_sync #(
        .STAGES (SYNC_STAGES)
    ) u_sync (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pin_i  (external_trigger_pin_i),
        .fall_o (trig_fall)
    );

    // one byte lane carries every register; other lanes read zero
    function automatic logic [DATA_W-1:0] pad8(input logic [7:0] v);
        pad8 = {{(DATA_W-8){1'b0}}, v};
    endfunction : pad8

    // mode decode; baud generation takes over the timer when either uart select is set
    always_comb
    begin
        bus_req      = cyc_i & stb_i;
        wr_en        = bus_req & we_i & sel_i[0] & ~ack_reg;
        baud_mode    = control_reg[CTL_RX_SEL_BIT] | control_reg[CTL_TX_SEL_BIT];
        special_mode = baud_mode | mode_reg[MODE_CLK_OUT_BIT];
        capture_mode = ~special_mode & control_reg[CTL_CAP_SEL_BIT];
        reload_mode  = ~special_mode & ~control_reg[CTL_CAP_SEL_BIT];
        up_down      = mode_reg[MODE_UP_DOWN_BIT];
        ext_en       = control_reg[CTL_EXT_EN_BIT];
        // up/down reload ignores the pin edge altogether, enable has no say
        edge_act     = trig_fall & ext_en & ~(reload_mode & up_down);
        flag_set_ovf = timer_b_overflow_i & ~special_mode;
        flag_set_ext = edge_act;
        flag_toggle  = timer_b_overflow_i & reload_mode;
    end

    // register file next values; hardware events beat a software write in the same cycle
    always_comb
    begin
        control_next = control_reg;
        mode_next    = mode_reg;
        mask_next    = mask_reg;
        status_next  = status_reg;
        if (wr_en)
        begin
            unique case (adr_i)
                CONTROL_ADDR:    control_next = dat_i[7:0];
                MODE_ADDR:       mode_next    = dat_i[1:0];
                IRQ_STATUS_ADDR: status_next  = status_reg & ~dat_i[1:0];
                IRQ_MASK_ADDR:   mask_next    = dat_i[1:0];
                default:         ;
            endcase
        end
        // toggle first, then a pin edge forces the flag high
        if (flag_toggle)
            control_next[CTL_EXT_FLAG_BIT] = ~control_reg[CTL_EXT_FLAG_BIT];
        if (flag_set_ext)
            control_next[CTL_EXT_FLAG_BIT] = 1'b1;
        if (flag_set_ovf)
            control_next[CTL_OVERFLOW_BIT] = 1'b1;
        if (flag_set_ovf)
            status_next[IRQ_OVERFLOW_BIT] = 1'b1;
        if (flag_set_ext)
            status_next[IRQ_EXT_EVENT_BIT] = 1'b1;
    end

    // wishbone answer: one wait state, ack drops the cycle after it is given
    always_comb
    begin
        ack_next = bus_req & ~ack_reg;
        dat_next = dat_reg;
        if (bus_req & ~ack_reg)
        begin
            unique case (adr_i)
                CONTROL_ADDR:    dat_next = pad8(control_reg);
                MODE_ADDR:       dat_next = pad8({6'h00, mode_reg});
                IRQ_STATUS_ADDR: dat_next = pad8({6'h00, status_reg});
                IRQ_MASK_ADDR:   dat_next = pad8({6'h00, mask_reg});
                default:         dat_next = '0;
            endcase
        end
    end

    // outputs toward the datapath and uart, all taken from flip-flops
    always_comb
    begin
        capture_next   = edge_act & capture_mode;
        reload_next    = edge_act & reload_mode;
        // timer one overflows feed the uart unless this timer is selected
        rx_baud_next   = control_reg[CTL_RX_SEL_BIT] ? timer_b_overflow_i
                                                     : timer_a_overflow_i;
        tx_baud_next   = control_reg[CTL_TX_SEL_BIT] ? timer_b_overflow_i
                                                     : timer_a_overflow_i;
        timer_irq_next = control_next[CTL_OVERFLOW_BIT] | control_next[CTL_EXT_FLAG_BIT];
        irq_next       = |(status_next & mask_next);  // a new mask counts at once, no one-cycle lag
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            control_reg   <= CONTROL_RESET;
            mode_reg      <= MODE_RESET;
            status_reg    <= IRQ_RESET;
            mask_reg      <= IRQ_RESET;
            ack_reg       <= 1'b0;
            dat_reg       <= '0;
            capture_reg   <= 1'b0;
            reload_reg    <= 1'b0;
            rx_baud_reg   <= 1'b0;
            tx_baud_reg   <= 1'b0;
            timer_irq_reg <= 1'b0;
            irq_reg       <= 1'b0;
        end
        else
        begin
            control_reg   <= control_next;
            mode_reg      <= mode_next;
            status_reg    <= status_next;
            mask_reg      <= mask_next;
            ack_reg       <= ack_next;
            dat_reg       <= dat_next;
            capture_reg   <= capture_next;
            reload_reg    <= reload_next;
            rx_baud_reg   <= rx_baud_next;
            tx_baud_reg   <= tx_baud_next;
            timer_irq_reg <= timer_irq_next;
            irq_reg       <= irq_next;
        end
    end

    // port drive
    assign dat_o                  = dat_reg;
    assign ack_o                  = ack_reg;
    assign timer_b_run_o          = control_reg[CTL_RUN_BIT];
    assign count_events_o         = control_reg[CTL_CNT_SEL_BIT];
    assign up_down_count_enable_o = mode_reg[MODE_UP_DOWN_BIT];
    assign capture_o              = capture_reg;
    assign reload_o               = reload_reg;
    assign uart_rx_baud_o         = rx_baud_reg;
    assign uart_tx_baud_o         = tx_baud_reg;
    assign timer_irq_o            = timer_irq_reg;
    assign irq_o                  = irq_reg;

    // checks on the flag, trigger, baud source, bus ack and interrupt behaviour
    AST_NO_OVF_IN_SPECIAL: assert property (@(posedge clk_i) disable iff (rst_i)
        (special_mode && !control_reg[CTL_OVERFLOW_BIT] && !wr_en) |=> !control_reg[CTL_OVERFLOW_BIT])
        else $error("overflow flag set in baud or clock-out mode");

    AST_OVF_ONLY_SW_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
        (control_reg[CTL_OVERFLOW_BIT] && !(wr_en && adr_i == CONTROL_ADDR)) |=> control_reg[CTL_OVERFLOW_BIT])
        else $error("overflow flag cleared without a software write");

    AST_EDGE_SETS_EXT: assert property (@(posedge clk_i) disable iff (rst_i)
        (trig_fall && ext_en && !(reload_mode && up_down)) |=> control_reg[CTL_EXT_FLAG_BIT])
        else $error("enabled falling edge did not set external flag");

    AST_TOGGLE_EXT: assert property (@(posedge clk_i) disable iff (rst_i)
        (flag_toggle && !flag_set_ext && !wr_en)
        |=> control_reg[CTL_EXT_FLAG_BIT] != $past(control_reg[CTL_EXT_FLAG_BIT]))
        else $error("auto-reload overflow did not invert external flag");

    AST_EXT_NO_HW_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
        (control_reg[CTL_EXT_FLAG_BIT] && !flag_toggle && !(wr_en && adr_i == CONTROL_ADDR))
        |=> control_reg[CTL_EXT_FLAG_BIT])
        else $error("external flag cleared by hardware");

    AST_RX_BAUD_SRC: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 uart_rx_baud_o == ($past(control_reg[CTL_RX_SEL_BIT]) ? $past(timer_b_overflow_i)
                                                                   : $past(timer_a_overflow_i)))
        else $error("receive baud pulse from wrong timer");

    AST_TX_BAUD_SRC: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 uart_tx_baud_o == ($past(control_reg[CTL_TX_SEL_BIT]) ? $past(timer_b_overflow_i)
                                                                   : $past(timer_a_overflow_i)))
        else $error("transmit baud pulse from wrong timer");

    AST_CAPTURE_ON_EDGE: assert property (@(posedge clk_i) disable iff (rst_i)
        (trig_fall && ext_en && capture_mode) |=> (capture_o && !reload_o && timer_irq_o))
        else $error("capture edge gave no capture and interrupt");

    AST_UPDOWN_IGNORES: assert property (@(posedge clk_i) disable iff (rst_i)
        (reload_mode && up_down) |=> !reload_o && !capture_o)
        else $error("trigger acted in up/down reload mode");

    AST_SPECIAL_NO_CAPTURE: assert property (@(posedge clk_i) disable iff (rst_i)
        (trig_fall && ext_en && special_mode) |=> (!capture_o && !reload_o && control_reg[CTL_EXT_FLAG_BIT]))
        else $error("special mode edge handled wrongly");

    AST_DISABLED_IGNORES: assert property (@(posedge clk_i) disable iff (rst_i)
        (!ext_en && !control_reg[CTL_EXT_FLAG_BIT] && !flag_toggle && !wr_en) |=> !control_reg[CTL_EXT_FLAG_BIT])
        else $error("trigger pin acted while disabled");

    AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i)
        (control_reg[CTL_OVERFLOW_BIT] || control_reg[CTL_EXT_FLAG_BIT]) |-> timer_irq_o)
        else $error("interrupt request low while a flag is set");

    AST_ACK_ONE_CYCLE: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held for more than one cycle");

    AST_RELOAD_ON_EDGE: assert property (@(posedge clk_i) disable iff (rst_i)
        (trig_fall && ext_en && reload_mode && !up_down) |=> (reload_o && !capture_o && timer_irq_o))
        else $error("reload edge gave no reload and interrupt");

    AST_SPECIAL_EVENT_STATUS: assert property (@(posedge clk_i) disable iff (rst_i)
        (trig_fall && ext_en && special_mode) |=> status_reg[IRQ_EXT_EVENT_BIT])
        else $error("special mode edge raised no interrupt event");

    AST_STATUS_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr_en && adr_i == IRQ_STATUS_ADDR) |=> ((status_reg & $past(status_reg)) == $past(status_reg)))
        else $error("interrupt status bit dropped without a clearing write");

    AST_IRQ_MASKED: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o == |(status_reg & mask_reg))
        else $error("interrupt output differs from masked status");

endmodule : timer_b_ctrl

// >>> bench/far_side_model.sv
`timescale 1ns/1ns

module far_side_model
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // baud pulses coming back from the block
    input  wire logic rx_baud_i,
    input  wire logic tx_baud_i,
    // trigger pin and the two counters' overflow pulses
    output logic      pin_o,
    output logic      ovf_b_o,
    output logic      ovf_a_o
);
    int rx_count;
    int tx_count;

    // pin idles high, so a fall is only seen when we make one
    initial
    begin
        pin_o   = 1'b1;
        ovf_b_o = 1'b0;
        ovf_a_o = 1'b0;
    end

    // baud pulses are one cycle wide, so one count per high sample
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_count <= 0;
            tx_count <= 0;
        end
        else
        begin
            rx_count <= rx_count + int'(rx_baud_i === 1'b1);
            tx_count <= tx_count + int'(tx_baud_i === 1'b1);
        end
    end

    // low and high phases both outlast the three-stage synchroniser
    task automatic fall_pin();
        @(posedge clk_i);
        pin_o <= 1'b0;
        repeat (5) @(posedge clk_i);
        pin_o <= 1'b1;
        repeat (5) @(posedge clk_i);
    endtask : fall_pin

    // one-cycle overflow pulse from this timer (b) or the other (a)
    task automatic pulse(input logic from_b);
        @(posedge clk_i);
        if (from_b)
            ovf_b_o <= 1'b1;
        else
            ovf_a_o <= 1'b1;
        @(posedge clk_i);
        ovf_b_o <= 1'b0;
        ovf_a_o <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask : pulse
endmodule : far_side_model

// >>> bench/test_timer_b_ctrl.sv
`timescale 1ns/1ns

module test_timer_b_ctrl;
    import timer_b_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [3:0]  adr_i = 4'h0, sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000, dat_o;
    logic        ack_o, ovf_b, ovf_a, pin, run, cnt_ev, updn, cap, rel, rx_baud, tx_baud, tirq, irq;
    int          n_fail = 0, n_compared = 0, n_cap = 0, n_rel = 0;

    always #20 clk_i = ~clk_i;

    timer_b_ctrl timer_b_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .timer_b_overflow_i(ovf_b),
        .timer_a_overflow_i(ovf_a), .timer_b_run_o(run), .count_events_o(cnt_ev), .up_down_count_enable_o(updn),
        .capture_o(cap), .reload_o(rel), .external_trigger_pin_i(pin), .uart_rx_baud_o(rx_baud),
        .uart_tx_baud_o(tx_baud), .timer_irq_o(tirq), .irq_o(irq));

    far_side_model far_side_model_inst (.clk_i(clk_i), .rst_i(rst_i), .rx_baud_i(rx_baud), .tx_baud_i(tx_baud),
        .pin_o(pin), .ovf_b_o(ovf_b), .ovf_a_o(ovf_a));

    // capture and reload are single-cycle strobes, so count them as they pass
    always @(posedge clk_i)
    begin
        n_cap <= n_cap + int'(cap === 1'b1);
        n_rel <= n_rel + int'(rel === 1'b1);
    end

    task automatic conclude();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // classic cycle: hold everything until ack is sampled, then drop for a cycle
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
        int i;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= {24'h00_0000, d};
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk_i);
            if (ack_o === 1'b1)
                break;
        end
        q = dat_o;
        if (i == 20)
        begin
            n_fail++;
            conclude();
        end
        else
        begin
            cyc_i <= 1'b0;
            stb_i <= 1'b0;
            we_i  <= 1'b0;
        end
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, {24'h00_0000, exp});
    endtask : rd

    // every register starts cleared; a hole in the map reads zero
    task automatic t_reset();
        rd(CONTROL_ADDR, 8'h00);
        rd(MODE_ADDR, 8'h00);
        rd(IRQ_STATUS_ADDR, 8'h00);
        rd(IRQ_MASK_ADDR, 8'h00);
        rd(4'h2, 8'h00);
        chk(32'(tirq), 32'h0000_0000);
    endtask : t_reset

    task automatic t_run_sel();
        wr(CONTROL_ADDR, 8'h06);
        chk(32'(run), 32'h0000_0001);
        chk(32'(cnt_ev), 32'h0000_0001);
        wr(CONTROL_ADDR, 8'h00);
        chk(32'({run, cnt_ev}), 32'h0000_0000);
        wr(MODE_ADDR, 8'h01);
        chk(32'(updn), 32'h0000_0001);
        wr(MODE_ADDR, 8'h00);
    endtask : t_run_sel

    // auto-reload: overflow sets its flag and inverts the event flag
    task automatic t_overflow();
        far_side_model_inst.pulse(1'b1);
        rd(CONTROL_ADDR, 8'hC0);
        chk(32'(tirq), 32'h0000_0001);
        far_side_model_inst.pulse(1'b1);
        rd(CONTROL_ADDR, 8'h80);
        wr(CONTROL_ADDR, 8'h00);
        rd(CONTROL_ADDR, 8'h00);
        chk(32'(tirq), 32'h0000_0000);
    endtask : t_overflow

    task automatic t_baud();
        int rx0, tx0;
        wr(CONTROL_ADDR, 8'h30);
        rx0 = far_side_model_inst.rx_count;
        tx0 = far_side_model_inst.tx_count;
        far_side_model_inst.pulse(1'b1);
        rd(CONTROL_ADDR, 8'h30);
        chk(32'(far_side_model_inst.rx_count - rx0), 32'h0000_0001);
        chk(32'(far_side_model_inst.tx_count - tx0), 32'h0000_0001);
        wr(CONTROL_ADDR, 8'h20);
        far_side_model_inst.pulse(1'b0);
        chk(32'(far_side_model_inst.tx_count - tx0), 32'h0000_0002);
        far_side_model_inst.pulse(1'b1);
        chk(32'(far_side_model_inst.rx_count - rx0), 32'h0000_0002);
        chk(32'(far_side_model_inst.tx_count - tx0), 32'h0000_0002);
        wr(CONTROL_ADDR, 8'h00);
        far_side_model_inst.pulse(1'b0);
        chk(32'(far_side_model_inst.rx_count - rx0), 32'h0000_0003);
        chk(32'(far_side_model_inst.tx_count - tx0), 32'h0000_0003);
        wr(IRQ_STATUS_ADDR, 8'h03);
    endtask : t_baud

    // capture mode with masked-in event interrupt, then write-one-to-clear
    task automatic t_capture();
        wr(IRQ_MASK_ADDR, 8'h02);
        wr(CONTROL_ADDR, 8'h01);
        far_side_model_inst.fall_pin();
        chk(32'(n_cap), 32'h0000_0000);
        rd(CONTROL_ADDR, 8'h01);
        wr(CONTROL_ADDR, 8'h09);
        far_side_model_inst.fall_pin();
        chk(32'(n_cap), 32'h0000_0001);
        chk(32'(n_rel), 32'h0000_0000);
        rd(CONTROL_ADDR, 8'h49);
        chk(32'({tirq, irq}), 32'h0000_0003);
        rd(IRQ_STATUS_ADDR, 8'h02);
        wr(IRQ_STATUS_ADDR, 8'h02);
        chk(32'(irq), 32'h0000_0000);
        wr(CONTROL_ADDR, 8'h09);
        chk(32'(tirq), 32'h0000_0000);
        wr(IRQ_MASK_ADDR, 8'h00);
    endtask : t_capture

    // reload acts only with up/down counting off
    task automatic t_reload();
        wr(CONTROL_ADDR, 8'h08);
        far_side_model_inst.fall_pin();
        chk(32'(n_rel), 32'h0000_0001);
        rd(CONTROL_ADDR, 8'h48);
        wr(CONTROL_ADDR, 8'h08);
        wr(MODE_ADDR, 8'h01);
        far_side_model_inst.fall_pin();
        chk(32'(n_rel), 32'h0000_0001);
        rd(CONTROL_ADDR, 8'h08);
        wr(MODE_ADDR, 8'h00);
    endtask : t_reload

    // baud mode counts as another mode: flag and interrupt, no strobe
    task automatic t_other();
        wr(IRQ_STATUS_ADDR, 8'h03);
        wr(CONTROL_ADDR, 8'h18);
        far_side_model_inst.fall_pin();
        chk(32'(n_cap + n_rel), 32'h0000_0002);
        rd(CONTROL_ADDR, 8'h58);
        rd(IRQ_STATUS_ADDR, 8'h02);
        chk(32'(tirq), 32'h0000_0001);
        // clock-out mode is the other special mode: an overflow must leave both flags alone
        wr(CONTROL_ADDR, 8'h00);
        wr(MODE_ADDR, 8'h02);
        rd(MODE_ADDR, 8'h02);
        far_side_model_inst.pulse(1'b1);
        rd(CONTROL_ADDR, 8'h00);
        rd(IRQ_STATUS_ADDR, 8'h02);
        chk(32'(tirq), 32'h0000_0000);
        wr(MODE_ADDR, 8'h00);
    endtask : t_other

    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_run_sel();
        t_overflow();
        t_baud();
        t_capture();
        t_reload();
        t_other();
        conclude();
    end
endmodule : test_timer_b_ctrl
